// ---- core/acd_consts.svh ----
// What this block does
// - Next block address is the link value added to the unit base.
// - End-of-chain bit 31 sends unit to idle, always raising idle event.
// - Suspend bit 30 sends unit to suspended; not-active event only if enabled.
// - Interrupt bit 29 raises command-done event; clear bit raises none.
// - Command code bits 18:16 equal to 101 selects microcode download.
// - Command code 110 selects register dump.
// - Host clears completion bit 15; device sets it when the command ends.
// - Status bit 13 is success; zero with completion set means error.
// - Download reads 64 words after the header into microcode RAM.
// - After a good download the loaded microcode runs until reset.
// - Dump writes a 596-byte area at the unit base plus the 32-bit buffer pointer.
// - Dump pushes a command byte, then waits for the dump marker.
// - Dump copies MAC-side registers via status FIFO, then parallel ones.
// - After dump data, status with completion and success set, then finish.
//
// Purpose: Constants of the action command unit
// Assumes: Byte addressed host memory, 32-bit words
// Notes: Definitions only
`ifndef ACD_CONSTS_SVH
`define ACD_CONSTS_SVH
`define ACD_OFF_CTRL 6'h00
`define ACD_OFF_BASE 6'h04
`define ACD_OFF_PTR 6'h08
`define ACD_OFF_STAT 6'h0c
`define ACD_OFF_UCIDX 6'h10
`define ACD_OFF_UCDATA 6'h14
`define ACD_CTRL_START 0
`define ACD_CTRL_RESUME 1
`define ACD_CTRL_CNAEN 2
`define ACD_HDR_EL 31
`define ACD_HDR_S 30
`define ACD_HDR_I 29
`define ACD_HDR_CMD_HI 18
`define ACD_HDR_CMD_LO 16
`define ACD_HDR_C 15
`define ACD_HDR_OK 13
`define ACD_CMD_UCODE 3'h5
`define ACD_CMD_DUMP 3'h6
`define ACD_OFF_LINK 32'h0000_0004
`define ACD_OFF_BODY 32'h0000_0008
`define ACD_UC_WORDS 8'h40
`define ACD_DUMP_BYTES 596
`define ACD_DUMP_WORDS 8'h95
`define ACD_DUMP_MAC_WORDS 8'h14
`define ACD_DUMP_CMD_BYTE 8'h06
`define ACD_CU_IDLE 2'h0
`define ACD_CU_SUSP 2'h1
`define ACD_CU_ACTIVE 2'h2
`endif

// ---- core/acd_pkg.sv ----
// Purpose: Types of the action command unit
// Assumes: Constants come from acd_consts.svh
// Notes: One-hot states
package acd_pkg;
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_SUSP = 12'h002,
    ST_HDR = 12'h004,
    ST_LINK = 12'h008,
    ST_UC = 12'h010,
    ST_DPTR = 12'h020,
    ST_DCMD = 12'h040,
    ST_DWAIT = 12'h080,
    ST_DMAC = 12'h100,
    ST_DPAR = 12'h200,
    ST_WB = 12'h400,
    ST_DONE = 12'h800
  } acd_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } acd_mem_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } acd_mem_rsp_t;

  typedef struct packed {
    logic cx;
    logic unit_not_active_event;
    logic ci;
  } acd_events_t;

  typedef struct packed {
    acd_state_t state;
    logic [31:0] cu_base;
    logic [31:0] cb_ptr;
    logic [31:0] cb_addr;
    logic [31:0] hdr;
    logic [31:0] link;
    logic [31:0] dump_buf;
    logic [7:0] cnt;
    logic cna_en;
    logic ucode_on;
    logic err;
    logic last_err;
    logic dph_wr;
    logic [5:0] dph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    acd_mem_req_t mem;
    logic tx_valid;
    logic [7:0] tx_data;
    logic stat_ready;
    logic [7:0] par_idx;
    acd_events_t ev;
    logic ram_we;
    logic [5:0] ram_waddr;
    logic [31:0] ram_wdata;
    logic [5:0] ram_raddr;
  } acd_regs_t;
endpackage

// ---- core/acd_ucode_ram.sv ----
// Purpose: Microcode patch store, 64 words of flip-flops
// Assumes: One write port, one asynchronous read port
// Notes: Contents are not cleared by reset
`timescale 1ns/1ps
module acd_ucode_ram (
  input wire logic hclk,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [5:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:63];

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// ---- core/acd_cmd_unit.sv ----
// Purpose: Command unit for microcode download and register dump blocks
// Assumes: AHB-Lite register slave, bus-master memory port on hclk
// Notes: Memory requests are held until acknowledged
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "acd_consts.svh"
module acd_cmd_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output acd_pkg::acd_mem_req_t mem_out,
  input wire acd_pkg::acd_mem_rsp_t mem_in,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic dump_marker,
  input wire logic stat_valid,
  input wire logic [31:0] stat_data,
  output logic stat_ready,
  output logic [7:0] par_idx,
  input wire logic [31:0] par_rdata,
  output acd_pkg::acd_events_t events,
  output logic ucode_on
);
  acd_pkg::acd_regs_t r;
  acd_pkg::acd_regs_t n;
  logic [31:0] uc_rdata;
  logic mem_done;
  logic [2:0] cmd;
  logic [31:0] ahb_rd;

  acd_ucode_ram u_ram (
    .hclk(hclk),
    .we(r.ram_we),
    .waddr(r.ram_waddr),
    .wdata(r.ram_wdata),
    .raddr(r.ram_raddr),
    .rdata(uc_rdata)
  );

  function automatic logic [1:0] cu_code(input acd_pkg::acd_state_t s);
    if (s == acd_pkg::ST_IDLE) begin
      return `ACD_CU_IDLE;
    end else if (s == acd_pkg::ST_SUSP) begin
      return `ACD_CU_SUSP;
    end
    return `ACD_CU_ACTIVE;
  endfunction

  assign mem_done = r.mem.req && mem_in.ack;
  assign cmd = r.hdr[`ACD_HDR_CMD_HI:`ACD_HDR_CMD_LO];

  always_comb begin
    unique case (haddr[5:0])
      `ACD_OFF_CTRL: ahb_rd = {29'h0, r.cna_en, 2'h0};
      `ACD_OFF_BASE: ahb_rd = r.cu_base;
      `ACD_OFF_PTR: ahb_rd = r.cb_ptr;
      `ACD_OFF_STAT: ahb_rd = {26'h0, r.last_err, r.ucode_on, 2'h0,
                               cu_code(r.state)};
      `ACD_OFF_UCIDX: ahb_rd = {26'h0, r.ram_raddr};
      `ACD_OFF_UCDATA: ahb_rd = uc_rdata;
      default: ahb_rd = 32'h0;
    endcase
  end

  always_comb begin
    n = r;
    n.ev = '0;
    n.ram_we = 1'b0;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    // Zero wait state: read data is formed in the address phase
    n.dph_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      n.dph_wr = hwrite;
      n.dph_addr = haddr[5:0];
      n.hrdata = hwrite ? 32'h0 : (haddr[31:6] == 26'h0 ? ahb_rd : 32'h0);
    end
    if (mem_done) begin
      n.mem.req = 1'b0;
      if (mem_in.err) begin
        n.err = 1'b1;
      end
    end
    unique case (r.state)
      acd_pkg::ST_IDLE, acd_pkg::ST_SUSP: begin
      end
      acd_pkg::ST_HDR: begin
        if (!r.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b0, addr: r.cb_addr, wdata: 32'h0};
        end else if (mem_in.ack) begin
          n.hdr = mem_in.rdata;
          n.state = acd_pkg::ST_LINK;
        end
      end
      acd_pkg::ST_LINK: begin
        if (!r.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b0, addr: r.cb_addr + `ACD_OFF_LINK,
                    wdata: 32'h0};
        end else if (mem_in.ack) begin
          n.link = mem_in.rdata;
          n.cnt = 8'h0;
          if (cmd == `ACD_CMD_UCODE) begin
            n.state = acd_pkg::ST_UC;
          end else if (cmd == `ACD_CMD_DUMP) begin
            n.state = acd_pkg::ST_DPTR;
          end else begin
            // Unsupported code here: finish with success clear
            n.err = 1'b1;
            n.state = acd_pkg::ST_WB;
          end
        end
      end
      acd_pkg::ST_UC: begin
        if (!r.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b0, wdata: 32'h0,
                    addr: r.cb_addr + `ACD_OFF_BODY + {22'h0, r.cnt, 2'h0}};
        end else if (mem_in.ack) begin
          n.ram_we = 1'b1;
          n.ram_waddr = r.cnt[5:0];
          n.ram_wdata = mem_in.rdata;
          n.cnt = r.cnt + 8'h1;
          if (r.cnt == `ACD_UC_WORDS - 8'h1) begin
            n.state = acd_pkg::ST_WB;
          end
        end
      end
      acd_pkg::ST_DPTR: begin
        if (!r.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b0, addr: r.cb_addr + `ACD_OFF_BODY,
                    wdata: 32'h0};
        end else if (mem_in.ack) begin
          n.dump_buf = r.cu_base + mem_in.rdata;
          n.tx_valid = 1'b1;
          n.tx_data = `ACD_DUMP_CMD_BYTE;
          n.state = acd_pkg::ST_DCMD;
        end
      end
      acd_pkg::ST_DCMD: begin
        if (tx_ready) begin
          n.tx_valid = 1'b0;
          n.state = acd_pkg::ST_DWAIT;
        end
      end
      acd_pkg::ST_DWAIT: begin
        if (dump_marker) begin
          n.stat_ready = 1'b1;
          n.state = acd_pkg::ST_DMAC;
        end
      end
      acd_pkg::ST_DMAC: begin
        // One word in flight: the FIFO is stalled while a write is pending
        if (r.stat_ready && stat_valid) begin
          n.stat_ready = 1'b0;
          n.mem = '{req: 1'b1, we: 1'b1, wdata: stat_data,
                    addr: r.dump_buf + {22'h0, r.cnt, 2'h0}};
        end else if (mem_done) begin
          n.cnt = r.cnt + 8'h1;
          if (r.cnt == `ACD_DUMP_MAC_WORDS - 8'h1) begin
            n.par_idx = 8'h0;
            n.state = acd_pkg::ST_DPAR;
          end else begin
            n.stat_ready = 1'b1;
          end
        end
      end
      acd_pkg::ST_DPAR: begin
        if (!r.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b1, wdata: par_rdata,
                    addr: r.dump_buf + {22'h0, r.cnt, 2'h0}};
        end else if (mem_in.ack) begin
          n.cnt = r.cnt + 8'h1;
          n.par_idx = r.par_idx + 8'h1;
          if (r.cnt == `ACD_DUMP_WORDS - 8'h1) begin
            n.state = acd_pkg::ST_WB;
          end
        end
      end
      acd_pkg::ST_WB: begin
        if (!r.mem.req) begin
          n.mem.req = 1'b1;
          n.mem.we = 1'b1;
          n.mem.addr = r.cb_addr;
          n.mem.wdata = {r.hdr[31:16], 1'b1, 1'b0, ~r.err, 13'h0};
        end else if (mem_in.ack) begin
          n.state = acd_pkg::ST_DONE;
        end
      end
      acd_pkg::ST_DONE: begin
        n.ev.cx = r.hdr[`ACD_HDR_I];
        n.last_err = r.err;
        if (cmd == `ACD_CMD_UCODE && !r.err) begin
          n.ucode_on = 1'b1;
        end
        n.cb_addr = r.cu_base + r.link;
        n.err = 1'b0;
        if (r.hdr[`ACD_HDR_EL]) begin
          n.ev.ci = 1'b1;
          n.ev.unit_not_active_event = 1'b1;
          n.state = acd_pkg::ST_IDLE;
        end else if (r.hdr[`ACD_HDR_S]) begin
          n.ev.unit_not_active_event = r.cna_en;
          n.state = acd_pkg::ST_SUSP;
        end else begin
          n.state = acd_pkg::ST_HDR;
        end
      end
    endcase
    // Register writes land in the data phase
    if (r.dph_wr) begin
      unique case (r.dph_addr)
        `ACD_OFF_CTRL: begin
          n.cna_en = hwdata[`ACD_CTRL_CNAEN];
          if (hwdata[`ACD_CTRL_START] && (r.state == acd_pkg::ST_IDLE ||
              r.state == acd_pkg::ST_SUSP)) begin
            n.cb_addr = r.cu_base + r.cb_ptr;
            n.state = acd_pkg::ST_HDR;
          end else if (hwdata[`ACD_CTRL_RESUME] &&
                       r.state == acd_pkg::ST_SUSP) begin
            n.state = acd_pkg::ST_HDR;
          end
        end
        `ACD_OFF_BASE: n.cu_base = hwdata;
        `ACD_OFF_PTR: n.cb_ptr = hwdata;
        `ACD_OFF_UCIDX: n.ram_raddr = hwdata[5:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.state <= acd_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign mem_out = r.mem;
  assign tx_valid = r.tx_valid;
  assign tx_data = r.tx_data;
  assign stat_ready = r.stat_ready;
  assign par_idx = r.par_idx;
  assign events = r.ev;
  assign ucode_on = r.ucode_on;

  link_next_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_DONE |=> r.cb_addr == $past(r.cu_base + r.link))
    else $error("next block address not base plus link");

  end_chain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_DONE && r.hdr[`ACD_HDR_EL]
      |=> events.ci && events.unit_not_active_event && r.state == acd_pkg::ST_IDLE)
    else $error("end of chain did not idle with event");

  suspend_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_DONE && !r.hdr[`ACD_HDR_EL] && r.hdr[`ACD_HDR_S]
      |=> r.state == acd_pkg::ST_SUSP && events.unit_not_active_event == $past(r.cna_en))
    else $error("suspend transition wrong");

  done_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
    events.cx |-> $past(r.state == acd_pkg::ST_DONE && r.hdr[`ACD_HDR_I]))
    else $error("command done event without cause");

  status_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_WB && mem_out.req
      |-> mem_out.we && mem_out.wdata[`ACD_HDR_C]
        && mem_out.wdata[`ACD_HDR_OK] == !r.err)
    else $error("status write lacks completion or success");

  uc_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_UC && mem_done && r.cnt == 8'h3f
      |=> r.state == acd_pkg::ST_WB && r.ram_we && r.ram_waddr == 6'h3f)
    else $error("microcode load count wrong");

  uc_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(r.ucode_on) |-> r.ucode_on)
    else $error("loaded microcode dropped without reset");

  uc_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(r.ucode_on) |-> $past(!r.err && cmd == `ACD_CMD_UCODE))
    else $error("microcode switched after failed load");

  dump_marker_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_DWAIT && !dump_marker
      |=> r.state == acd_pkg::ST_DWAIT && !mem_out.req)
    else $error("dump moved on without marker");

  dump_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_DPAR |-> r.cnt >= `ACD_DUMP_MAC_WORDS)
    else $error("parallel registers before MAC registers");

  dump_size_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.state == acd_pkg::ST_DPAR && mem_done && r.cnt == 8'h94
      |=> r.state == acd_pkg::ST_WB ##1 mem_out.req && mem_out.we)
    else $error("dump did not end in status write");
endmodule

// ---- test/acd_mem_model.sv ----
// Purpose: Host memory answering the unit's bus-master port
// Assumes: Word addresses below 4 KB
// Notes: Latency and one faulting address come from the bench
`timescale 1ns/1ps
module acd_mem_model (
  input wire logic hclk,
  input wire acd_pkg::acd_mem_req_t req_in,
  input wire logic [3:0] lat,
  input wire logic [31:0] err_addr,
  output acd_pkg::acd_mem_rsp_t rsp_out
);
  logic [31:0] mem [0:1023];
  logic [3:0] cnt;
  initial begin
    rsp_out = '0;
    cnt = 4'h0;
  end
  always @(posedge hclk) begin
    rsp_out.ack <= 1'b0;
    rsp_out.err <= 1'b0;
    // Read data is only meaningful with ack, so it keeps moving
    rsp_out.rdata <= ~rsp_out.rdata;
    if (req_in.req && !rsp_out.ack) begin
      if (cnt < lat) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        rsp_out.ack <= 1'b1;
        rsp_out.err <= (req_in.addr == err_addr);
        if (req_in.we) begin
          mem[req_in.addr[11:2]] <= req_in.wdata;
        end else begin
          rsp_out.rdata <= mem[req_in.addr[11:2]];
        end
      end
    end
  end
endmodule

// ---- test/acd_cmd_unit_bench.sv ----
// Purpose: Self-checking bench of the action command unit
// Assumes: Blocks are built in the memory model before start
// Notes: Dump side partners are small processes here
`timescale 1ns/1ps
module acd_cmd_unit_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic tx_ready = 1'b0;
  logic dump_marker = 1'b0;
  logic stat_valid = 1'b0;
  logic [31:0] stat_data = 32'h0;
  logic [3:0] lat = 4'h0;
  logic [31:0] err_addr = 32'hffff_fffc;
  logic [31:0] par_rdata, hrdata, tx_word, d;
  logic hreadyout, hresp, tx_valid, stat_ready, ucode_on;
  logic [7:0] tx_data, par_idx;
  logic marker_done = 1'b0;
  acd_pkg::acd_mem_req_t mem_out;
  acd_pkg::acd_mem_rsp_t mem_in;
  acd_pkg::acd_events_t events;
  int err_count = 0;
  int cmp_count = 0;
  int n_cx = 0;
  int n_cna = 0;
  int n_ci = 0;
  int n_st = 0;
  int nn;
  always #4 hclk = ~hclk;
  assign par_rdata = {24'hc0de00, par_idx};
  acd_cmd_unit u_acd_cmd_unit (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mem_out(mem_out), .mem_in(mem_in), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .dump_marker(dump_marker),
    .stat_valid(stat_valid), .stat_data(stat_data),
    .stat_ready(stat_ready), .par_idx(par_idx), .par_rdata(par_rdata),
    .events(events), .ucode_on(ucode_on));
  acd_mem_model u_acd_mem_model (.hclk(hclk), .req_in(mem_out),
    .lat(lat), .err_addr(err_addr), .rsp_out(mem_in));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wait_for(ref int n, input int v);
    int k;
    k = 0;
    while (n < v && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    chk("event wait", k < 3000, 1);
  endtask
  // Blocks as host software builds them, reserved bits and C clear
  task put_uc(input int i, input logic [31:0] h, input logic [31:0] l);
    u_acd_mem_model.mem[i] = h;
    u_acd_mem_model.mem[i + 1] = l;
    for (int k = 0; k < 64; k++) begin
      u_acd_mem_model.mem[i + 2 + k] = 32'hbeef_0000 + k;
    end
  endtask
  always @(posedge hclk) begin
    n_cx <= n_cx + int'(events.cx);
    n_cna <= n_cna + int'(events.unit_not_active_event);
    n_ci <= n_ci + int'(events.ci);
    if (tx_valid && tx_ready) begin
      tx_word <= {24'h0, tx_data};
    end
    // One stall cycle before each byte is taken
    tx_ready <= tx_valid && !tx_ready;
    dump_marker <= tx_valid && tx_ready;
    if (dump_marker) begin
      marker_done <= 1'b1;
    end
    if (stat_valid && stat_ready) begin
      chk("stat before marker", marker_done, 1'b1);
    end
    nn = n_st + int'(stat_valid && stat_ready);
    n_st <= nn;
    stat_valid <= (nn < 20);
    stat_data <= (nn < 20) ? 32'h5000 + nn : ~stat_data;
  end
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 1024; i++) begin
      u_acd_mem_model.mem[i] = 32'h7777_0000 + i;
    end
    put_uc(32'h40, 32'h6005_0000, 32'h0000_0200);
    u_acd_mem_model.mem[32'hc0] = 32'h8006_0000;
    u_acd_mem_model.mem[32'hc2] = 32'h0000_0400;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 32'h0c, 32'h0);
    chk("status reset", d, 32'h0);
    chk("okay response", hresp, 1'b0);
    ahb(1'b0, 32'h3c, 32'h0);
    chk("unmapped", d, 32'h0);
    ahb(1'b1, 32'h04, 32'h100);
    ahb(1'b1, 32'h08, 32'h0);
    lat <= 4'h3;
    // Start with the not-active event disabled, so suspend stays silent
    ahb(1'b1, 32'h00, 32'h1);
    wait_for(n_cx, 1);
    repeat (2) @(posedge hclk);
    chk("uc status word", u_acd_mem_model.mem[32'h40], 32'h6005_a000);
    chk("uc cx", n_cx, 1);
    chk("uc cna off", n_cna, 0);
    chk("uc ci", n_ci, 0);
    ahb(1'b0, 32'h0c, 32'h0);
    chk("suspended", d, 32'h11);
    for (int k = 0; k < 64; k++) begin
      ahb(1'b1, 32'h10, k);
      ahb(1'b0, 32'h14, 32'h0);
      chk("ucode word", d, 32'hbeef_0000 + k);
    end
    lat <= 4'h0;
    ahb(1'b1, 32'h00, 32'h6);
    wait_for(n_ci, 1);
    repeat (2) @(posedge hclk);
    chk("dump status", u_acd_mem_model.mem[32'hc0], 32'h8006_a000);
    chk("dump byte", tx_word, 32'h06);
    for (int k = 0; k < 149; k++) begin
      chk("dump word", u_acd_mem_model.mem[32'h140 + k], (k < 20) ?
        32'h5000 + k : {24'hc0de00, 8'(k - 20)});
    end
    chk("dump end", u_acd_mem_model.mem[32'h1d5], 32'h7777_01d5);
    chk("dump cx", n_cx, 1);
    chk("dump cna", n_cna, 1);
    chk("ucode kept", ucode_on, 1'b1);
    ahb(1'b0, 32'h0c, 32'h0);
    chk("idle", d, 32'h10);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("ucode after reset", ucode_on, 1'b0);
    put_uc(32'h240, 32'ha005_0000, 32'h0);
    err_addr <= 32'h0000_0930;
    ahb(1'b1, 32'h04, 32'h100);
    ahb(1'b1, 32'h08, 32'h800);
    ahb(1'b1, 32'h00, 32'h1);
    wait_for(n_ci, 2);
    repeat (2) @(posedge hclk);
    chk("err status", u_acd_mem_model.mem[32'h240], 32'ha005_8000);
    chk("err ucode off", ucode_on, 1'b0);
    chk("err cx", n_cx, 2);
    ahb(1'b0, 32'h0c, 32'h0);
    chk("err flag", d, 32'h20);
    summarize();
  end
endmodule
